// >>> rtl/flidp_pkg.sv
// constants, decoders and types shared by both ends of the flash link
// assumes a 40 MHz pclk on both ends and a mode 0 serial link
package flidp_pkg;

	// opcodes
	localparam logic [7:0] OP_READ_ID         = 8'h9F;
	localparam logic [7:0] OP_PARAM_TABLE     = 8'h5A;
	localparam logic [7:0] OP_OTP_ERASE       = 8'h44;
	localparam logic [7:0] OP_OTP_PROGRAM     = 8'h42;
	localparam logic [7:0] OP_OTP_READ        = 8'h48;
	localparam logic [7:0] OP_SET_READ_PARAMS = 8'hC0;
	localparam logic [7:0] OP_WRITE_ENABLE    = 8'h06;
	localparam logic [7:0] OP_READ_STATUS     = 8'h05;
	localparam logic [7:0] OP_RESET_ENABLE    = 8'h66;
	localparam logic [7:0] OP_RESET           = 8'h99;

	// identification bytes: values are arbitrary
	localparam logic [7:0] MAKER_ID       = 8'h5C;
	localparam logic [7:0] MEMORY_TYPE_ID = 8'h40;
	localparam logic [7:0] CAPACITY_ID    = 8'h18;

	// bit and byte positions within a command
	localparam logic [11:0] BITS_OPCODE_ONLY = 12'h008;
	localparam logic [11:0] BITS_WITH_PARAM  = 12'h010;
	localparam logic [11:0] BITS_WITH_ADDR   = 12'h020;
	localparam logic [11:0] BITS_SATURATE    = 12'hFFF;
	localparam logic [8:0]  BYTE_ADDR_LAST   = 9'h003;
	localparam logic [8:0]  BYTE_FIRST_DATA  = 9'h004;
	localparam int          DUMMY_FIELD_LSB  = 4;
	localparam int          WRAP_FIELD_LSB   = 0;

	// values after reset, and the value of an erased byte
	localparam logic [1:0] DUMMY_FIELD_RESET = 2'h0;
	localparam logic [1:0] WRAP_FIELD_RESET  = 2'h0;
	localparam logic [7:0] ERASED_BYTE       = 8'hFF;

	// self-timed cycle lengths in pclk cycles
	localparam logic [7:0] ERASE_LAST_STEP = 8'hFF;
	localparam logic [7:0] PROGRAM_CYCLES  = 8'h10;

	// host timing
	localparam int         PCLK_PERIOD_NS      = 25;
	localparam int         LINK_HALF_PERIOD_NS = 200;
	localparam logic [3:0] SCLK_HALF_CYCLES    =
		4'(LINK_HALF_PERIOD_NS / PCLK_PERIOD_NS);

	// host register map
	localparam logic [11:0] REG_CONTROL = 12'h000;
	localparam logic [11:0] REG_TX      = 12'h004;
	localparam logic [11:0] REG_RX      = 12'h008;
	localparam logic [11:0] REG_STATUS  = 12'h00C;

	typedef enum logic [1:0]
	{
		OP_IDLE        = 2'b00,
		OP_ERASING     = 2'b01,
		OP_PROGRAMMING = 2'b10
	} flidp_op_state_type;

	// otp region number 1..3, 0 when the address selects none
	function automatic logic [1:0] flidp_otp_region(input logic [23:0] a);
		if (a[23:16] == 8'h00 && a[11:8] == 4'h0 && a[15:14] == 2'b00)
			return a[13:12];
		return 2'b00;
	endfunction : flidp_otp_region

	function automatic logic [3:0] flidp_dummy_clocks(input logic [1:0] f);
		return {1'b0, f, 1'b0} + 4'h2;
	endfunction : flidp_dummy_clocks

	function automatic logic [6:0] flidp_wrap_bytes(input logic [1:0] f);
		return 7'h08 << f;
	endfunction : flidp_wrap_bytes

	// parameter header table: signature then erased bytes
	function automatic logic [7:0] flidp_table_byte(input logic [7:0] a);
		case (a)
			8'h00:   return 8'h53;
			8'h01:   return 8'h46;
			8'h02:   return 8'h44;
			8'h03:   return 8'h50;
			default: return ERASED_BYTE;
		endcase
	endfunction : flidp_table_byte

endpackage : flidp_pkg

// >>> rtl/flidp_link_if.sv
// serial link between host controller and flash device
// the bench joins both modports; every signal has a single driver
`timescale 1ns/10ps
interface flidp_link_if;
	logic select_n;
	logic sclk;
	logic serial_in_pin;
	logic serial_out;

	modport device
	(
		input  select_n,
		input  sclk,
		input  serial_in_pin,
		output serial_out
	);
	modport host
	(
		output select_n,
		output sclk,
		output serial_in_pin,
		input  serial_out
	);
endinterface : flidp_link_if

// >>> rtl/flidp_device.sv
// flash device end: identification, parameter table, otp regions, read
// parameters; link pins are asynchronous and resynchronised to pclk
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/10ps

// Function
// - id opcode returns maker, type, capacity bytes
// - table data starts on 40th falling edge
// - host keeps table address high bits zero
// - otp erase needs write enable latch
// - otp address decodes regions one to three
// - erase only on select rise after exactly 32 bits
// - erase self-timed with busy shown
// - finished erase clears write enable latch
// - locked region ignores erase and program
// - program needs latch, address, 1-256 bytes
// - host holds select low whole program
// - otp read: address, dummy, then data
// - read offset wraps within region
// - otp read ignored while busy
// - quad mode param command sets dummy, wrap
// - param command rejected in serial mode
// - reset gives 8-byte wrap, 2 dummies
// - field codes map to clocks and bytes
// - serial wrap kept entering quad mode
// - host rewrites dummies after quad entry
module flidp_device
	import flidp_pkg::*;
(
	// system
	input  wire logic       pclk,
	input  wire logic       presetn,
	// link
	flidp_link_if.device    link,
	// mode and settings from surrounding logic
	input  wire logic       quad_instruction_mode,
	input  wire logic       serial_wrap_load,
	input  wire logic [1:0] serial_wrap_field,
	input  wire logic [2:0] otp_region_lock_bits,
	// state
	output logic            busy,
	output logic            write_enable_latch,
	output logic [3:0]      dummy_clocks,
	output logic [6:0]      wrap_bytes
);

	logic [2:0]         sclk_sync;
	logic [2:0]         sel_sync;
	logic [1:0]         din_sync;
	logic [11:0]        bit_cnt;
	logic [7:0]         shift_in;
	logic [7:0]         opcode;
	logic [15:0]        addr_hi;
	logic [7:0]         offset;
	logic [1:0]         region;
	logic [7:0]         shift_out;
	logic               prog_any;
	logic               reset_armed;
	logic [7:0]         op_cnt;
	logic [1:0]         busy_region;
	logic [1:0]         dummy_count_field;
	logic [1:0]         wrap_length_field;
	flidp_op_state_type op_state;
	logic [7:0]         otp_mem [0:767];

	logic        sclk_rise;
	logic        sclk_fall;
	logic        sel_low;
	logic        sel_rise;
	logic        byte_done;
	logic [8:0]  byte_idx;
	logic [7:0]  new_byte;
	logic [7:0]  cur_op;
	logic [23:0] full_addr;
	logic        region_open;
	logic        prog_write;
	logic [9:0]  mem_idx;
	logic [9:0]  erase_idx;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers; stage 0 feeds only stage 1
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			sclk_sync <= 3'h0;
			sel_sync  <= 3'h7;
			din_sync  <= 2'h0;
		end
		else
		begin
			sclk_sync <= {sclk_sync[1:0], link.sclk};
			sel_sync  <= {sel_sync[1:0], link.select_n};
			din_sync  <= {din_sync[0], link.serial_in_pin};
		end

	assign sclk_rise   = sclk_sync[1] & ~sclk_sync[2];
	assign sclk_fall   = ~sclk_sync[1] & sclk_sync[2];
	assign sel_low     = ~sel_sync[1];
	assign sel_rise    = sel_sync[1] & ~sel_sync[2];
	assign new_byte    = {shift_in[6:0], din_sync[1]};
	assign byte_done   = sel_low && sclk_rise && bit_cnt[2:0] == 3'h7;
	assign byte_idx    = bit_cnt[11:3];
	assign cur_op      = (byte_idx == 9'h000) ? new_byte : opcode;
	assign full_addr   = {addr_hi, new_byte};
	assign region_open = region != 2'b00
		&& !otp_region_lock_bits[region - 2'b01];
	assign mem_idx     = {region - 2'b01, offset};
	assign erase_idx   = {busy_region - 2'b01, op_cnt};
	assign prog_write  = byte_done && byte_idx >= BYTE_FIRST_DATA
		&& opcode == OP_OTP_PROGRAM && write_enable_latch
		&& op_state == OP_IDLE && region_open;

	////////////////////////////////////////////////////////////////////////
	// command shifter, sampled on rising link clock

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			bit_cnt  <= 12'h000;
			shift_in <= 8'h00;
			opcode   <= 8'h00;
			addr_hi  <= 16'h0000;
			offset   <= 8'h00;
			region   <= 2'b00;
		end
		else if (!sel_low)
			bit_cnt <= 12'h000;
		else if (sclk_rise)
		begin
			if (bit_cnt != BITS_SATURATE)
				bit_cnt <= bit_cnt + 12'h001;
			shift_in <= new_byte;
			if (byte_done && byte_idx == 9'h000)
				opcode <= (op_state == OP_IDLE || new_byte != OP_OTP_READ)
					? new_byte : 8'h00;
			else if (byte_done && byte_idx < BYTE_ADDR_LAST)
				addr_hi <= {addr_hi[7:0], new_byte};
			else if (byte_done && byte_idx == BYTE_ADDR_LAST)
			begin
				offset <= new_byte;
				region <= flidp_otp_region(full_addr);
			end
			else if (byte_done && (cur_op == OP_OTP_READ
				|| cur_op == OP_PARAM_TABLE || prog_write))
				offset <= offset + 8'h01;
		end

	////////////////////////////////////////////////////////////////////////
	// answer shifter, driven on falling link clock
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			shift_out       <= 8'h00;
			link.serial_out <= 1'b0;
		end
		else if (!sel_low)
		begin
			shift_out       <= 8'h00;
			link.serial_out <= 1'b0;
		end
		else if (byte_done)
		begin
			shift_out <= 8'h00;
			if (cur_op == OP_READ_ID && byte_idx == 9'h000)
				shift_out <= MAKER_ID;
			else if (cur_op == OP_READ_ID && byte_idx == 9'h001)
				shift_out <= MEMORY_TYPE_ID;
			else if (cur_op == OP_READ_ID && byte_idx == 9'h002)
				shift_out <= CAPACITY_ID;
			else if (cur_op == OP_READ_STATUS)
				shift_out <= {6'h00, write_enable_latch, busy};
			else if (cur_op == OP_PARAM_TABLE
				&& byte_idx >= BYTE_FIRST_DATA)
				shift_out <= flidp_table_byte(offset);
			else if (cur_op == OP_OTP_READ && byte_idx >= BYTE_FIRST_DATA
				&& op_state == OP_IDLE && region != 2'b00)
				shift_out <= otp_mem[mem_idx];
		end
		else if (sclk_fall)
		begin
			link.serial_out <= shift_out[7];
			shift_out       <= {shift_out[6:0], 1'b0};
		end

	////////////////////////////////////////////////////////////////////////
	// otp storage: programming only clears bits, erase walks one byte a cycle
	always_ff @(posedge pclk)
		if (op_state == OP_ERASING)
			otp_mem[erase_idx] <= ERASED_BYTE;
		else if (prog_write)
			otp_mem[mem_idx] <= otp_mem[mem_idx] & new_byte;

	////////////////////////////////////////////////////////////////////////
	// commands that act when select rises, and the self-timed cycles

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			op_state           <= OP_IDLE;
			op_cnt             <= 8'h00;
			busy_region        <= 2'b00;
			write_enable_latch <= 1'b0;
			prog_any           <= 1'b0;
			reset_armed        <= 1'b0;
			dummy_count_field  <= DUMMY_FIELD_RESET;
			wrap_length_field  <= WRAP_FIELD_RESET;
		end
		else if (op_state != OP_IDLE)
		begin
			op_cnt <= op_cnt + 8'h01;
			if ((op_state == OP_ERASING && op_cnt == ERASE_LAST_STEP)
				|| (op_state == OP_PROGRAMMING && op_cnt == PROGRAM_CYCLES))
			begin
				op_state           <= OP_IDLE;
				write_enable_latch <= 1'b0;
			end
		end
		else
		begin
			if (prog_write)
				prog_any <= 1'b1;
			if (serial_wrap_load && !quad_instruction_mode)
				wrap_length_field <= serial_wrap_field;
			if (sel_rise)
			begin
				prog_any    <= 1'b0;
				reset_armed <= opcode == OP_RESET_ENABLE
					&& bit_cnt == BITS_OPCODE_ONLY;
				op_cnt      <= 8'h00;
				busy_region <= region;
				if (opcode == OP_WRITE_ENABLE && bit_cnt == BITS_OPCODE_ONLY)
					write_enable_latch <= 1'b1;
				else if (opcode == OP_OTP_ERASE && bit_cnt == BITS_WITH_ADDR
					&& write_enable_latch
					&& region_open)
					op_state <= OP_ERASING;
				else if (opcode == OP_OTP_PROGRAM && prog_any)
					op_state <= OP_PROGRAMMING;
				else if (opcode == OP_SET_READ_PARAMS
					&& bit_cnt == BITS_WITH_PARAM
					&& quad_instruction_mode)
				begin
					dummy_count_field <=
						shift_in[DUMMY_FIELD_LSB +: 2];
					wrap_length_field <=
						shift_in[WRAP_FIELD_LSB +: 2];
				end
				else if (opcode == OP_RESET && reset_armed
					&& bit_cnt == BITS_OPCODE_ONLY)
				begin
					write_enable_latch <= 1'b0;
					dummy_count_field  <= DUMMY_FIELD_RESET;
					wrap_length_field  <= WRAP_FIELD_RESET;
				end
			end
		end

	////////////////////////////////////////////////////////////////////////
	// registered views of the settings
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			busy         <= 1'b0;
			dummy_clocks <= 4'h2;
			wrap_bytes   <= 7'h08;
		end
		else
		begin
			busy         <= op_state != OP_IDLE;
			dummy_clocks <= flidp_dummy_clocks(dummy_count_field);
			wrap_bytes   <= flidp_wrap_bytes(wrap_length_field);
		end

endmodule : flidp_device

// >>> rtl/flidp_host.sv
// host controller end: apb slave driving a byte-wide serial engine
// software builds each command byte by byte; select follows a control bit
`timescale 1ns/10ps
module flidp_host
	import flidp_pkg::*;
(
	// system
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// link
	flidp_link_if.host       link
);

	logic [1:0] miso_sync;
	logic       hold_select;
	logic       running;
	logic [3:0] div_cnt;
	logic [2:0] bit_idx;
	logic [7:0] tx_shift;
	logic [7:0] rx_byte;

	logic apb_write;
	logic tx_start;
	logic half_tick;
	logic mapped;

	assign apb_write = psel && penable && pready && pwrite;
	assign mapped    = paddr == REG_CONTROL || paddr == REG_TX
		|| paddr == REG_RX || paddr == REG_STATUS;
	// a byte may only start with select already low
	assign tx_start  = apb_write && paddr == REG_TX && !running
		&& !link.select_n;
	assign half_tick = div_cnt == SCLK_HALF_CYCLES - 4'h1;

	////////////////////////////////////////////////////////////////////////
	// apb: answer registered in setup, so no wait states

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata  <= 32'h0000_0000;
			if (psel && !penable && !pwrite && paddr == REG_CONTROL)
				prdata <= {31'h0000_0000, hold_select};
			else if (psel && !penable && !pwrite && paddr == REG_RX)
				prdata <= {24'h00_0000, rx_byte};
			else if (psel && !penable && !pwrite && paddr == REG_STATUS)
				prdata <= {30'h0000_0000, !link.select_n, running};
		end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			hold_select <= 1'b0;
		else if (apb_write && paddr == REG_CONTROL)
			hold_select <= pwdata[0];

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			miso_sync <= 2'h0;
		else
			miso_sync <= {miso_sync[0], link.serial_out};

	////////////////////////////////////////////////////////////////////////
	// serial engine: mode 0, sample on rise, shift on fall

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			link.select_n      <= 1'b1;
			link.sclk          <= 1'b0;
			link.serial_in_pin <= 1'b0;
			running            <= 1'b0;
			div_cnt            <= 4'h0;
			bit_idx            <= 3'h0;
			tx_shift           <= 8'h00;
			rx_byte            <= 8'h00;
		end
		else if (tx_start)
		begin
			running            <= 1'b1;
			div_cnt            <= 4'h0;
			bit_idx            <= 3'h0;
			tx_shift           <= pwdata[7:0];
			link.serial_in_pin <= pwdata[7];
		end
		else
		begin
			div_cnt <= half_tick ? 4'h0 : div_cnt + 4'h1;
			// select only moves between bytes, at a half-period tick
			if (!running && half_tick)
				link.select_n <= !hold_select;
			if (running && half_tick)
			begin
				link.sclk <= !link.sclk;
				if (!link.sclk)
					rx_byte <= {rx_byte[6:0], miso_sync[1]};
				else if (bit_idx == 3'h7)
					running <= 1'b0;
				else
				begin
					bit_idx            <= bit_idx + 3'h1;
					tx_shift           <= {tx_shift[6:0], 1'b0};
					link.serial_in_pin <= tx_shift[6];
				end
			end
		end

endmodule : flidp_host

// >>> sim/flidp_properties.sv
// link and device-state checks for the flash link
// assumes one pclk domain and an async active low presetn
`timescale 1ns/10ps
module flidp_properties
(
	// system
	input logic       pclk,
	input logic       presetn,
	// link
	input logic       select_n,
	input logic       sclk,
	input logic       serial_in_pin,
	input logic       serial_out,
	// device state
	input logic       quad_instruction_mode,
	input logic       busy,
	input logic       write_enable_latch,
	input logic [3:0] dummy_clocks,
	input logic [6:0] wrap_bytes
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// length of the current busy stretch; erase is the longest cycle
	logic [9:0] busy_run;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			busy_run <= 10'h000;
		else
			busy_run <= busy ? busy_run + 10'h001 : 10'h000;

	////////////////////////////////////////////////////////////
	property p_out_low_idle;
		select_n [*4] |-> !serial_out;
	endproperty
	a_out_low_idle: assert property (p_out_low_idle)
		else $error("data out not low while deselected");
	property p_out_on_fall;
		!select_n && !$past(select_n) && $changed(serial_out) |-> !sclk;
	endproperty
	a_out_on_fall: assert property (p_out_on_fall)
		else $error("data out moved while link clock high");
	property p_in_hold;
		sclk && $past(sclk) |-> $stable(serial_in_pin);
	endproperty
	a_in_hold: assert property (p_in_hold)
		else $error("data in moved while link clock high");
	property p_sclk_idle;
		select_n |-> !sclk;
	endproperty
	a_sclk_idle: assert property (p_sclk_idle)
		else $error("link clock not low while deselected");
	property p_dummy_set;
		$changed(dummy_clocks) |->
			$past(quad_instruction_mode) || dummy_clocks == 4'h2;
	endproperty
	a_dummy_set: assert property (p_dummy_set)
		else $error("dummy count changed outside quad mode");
	property p_codes;
		dummy_clocks inside {4'h2, 4'h4, 4'h6, 4'h8} &&
			wrap_bytes inside {7'h08, 7'h10, 7'h20, 7'h40};
	endproperty
	a_codes: assert property (p_codes)
		else $error("dummy or wrap setting off the code table");
	property p_busy_start;
		$rose(busy) |-> write_enable_latch && select_n;
	endproperty
	a_busy_start: assert property (p_busy_start)
		else $error("cycle started without latch or inside a frame");
	property p_wel_done;
		$fell(busy) |-> ##[0:2] !write_enable_latch;
	endproperty
	a_wel_done: assert property (p_wel_done)
		else $error("latch still set after cycle end");
	property p_busy_bounded;
		busy_run <= 10'h12C;
	endproperty
	a_busy_bounded: assert property (p_busy_bounded)
		else $error("busy held too long");

	c_busy: cover property ($rose(busy));
	c_dummy8: cover property (dummy_clocks == 4'h8);
	c_wrap64: cover property (wrap_bytes == 7'h40);
endmodule : flidp_properties

// >>> sim/tb_top.sv
// bench: host and device joined by the link, driven over apb
// assumes 25 ns pclk; commands are built byte by byte in tx_q
`timescale 1ns/10ps
module tb_top
	import flidp_pkg::*;
;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        quad_instruction_mode = 1'b0;
	logic        serial_wrap_load = 1'b0;
	logic [1:0]  serial_wrap_field = 2'h0;
	logic [2:0]  otp_region_lock_bits = 3'h0;
	logic        busy;
	logic        write_enable_latch;
	logic [3:0]  dummy_clocks;
	logic [6:0]  wrap_bytes;
	int          n_mismatch = 0;
	int          checks = 0;
	logic [31:0] rd;
	logic        err;
	logic [7:0]  tx_q[$];
	logic [7:0]  rx_q[$];

	flidp_link_if flidp_link_if_inst();
	flidp_host flidp_host_inst(.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr,
		.link(flidp_link_if_inst.host));
	flidp_device flidp_device_inst(.pclk, .presetn,
		.link(flidp_link_if_inst.device), .quad_instruction_mode,
		.serial_wrap_load, .serial_wrap_field, .otp_region_lock_bits,
		.busy, .write_enable_latch, .dummy_clocks, .wrap_bytes);
	flidp_properties flidp_properties_inst(.pclk, .presetn,
		.select_n(flidp_link_if_inst.select_n),
		.sclk(flidp_link_if_inst.sclk),
		.serial_in_pin(flidp_link_if_inst.serial_in_pin),
		.serial_out(flidp_link_if_inst.serial_out),
		.quad_instruction_mode, .busy, .write_enable_latch,
		.dummy_clocks, .wrap_bytes);

	initial
		forever
			#12.5 pclk = ~pclk;

	////////////////////////////////////////////////////////////
	task automatic summarize();
		if (n_mismatch == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize

	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		checks++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic give_up(input string nm);
		chk(nm, 32'h0000_0001, 32'h0000_0000);
		summarize();
	endtask : give_up

	// entered just after a rising edge; holds until pready
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		for (n = 0; n < 50 && pready !== 1'b1; n++)
			@(posedge pclk);
		if (n == 50)
			give_up("apb answer");
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge: a following call must not rewrite psel in this step
		@(posedge pclk);
	endtask : apb

	task automatic poll(input int b, input logic v);
		for (int i = 0; i < 300; i++)
		begin
			apb(1'b0, REG_STATUS, 32'h0000_0000);
			if (rd[b] === v)
				return;
		end
		give_up("status poll");
	endtask : poll

	// one framed command: every tx_q byte out, every reply into rx_q
	task automatic run();
		rx_q = {};
		apb(1'b1, REG_CONTROL, 32'h0000_0001);
		poll(1, 1'b1);
		foreach (tx_q[i])
		begin
			apb(1'b1, REG_TX, {24'h00_0000, tx_q[i]});
			poll(0, 1'b1);
			poll(0, 1'b0);
			apb(1'b0, REG_RX, 32'h0000_0000);
			rx_q.push_back(rd[7:0]);
		end
		apb(1'b1, REG_CONTROL, 32'h0000_0000);
		poll(1, 1'b0);
		// device sees select rise only after its synchroniser
		repeat (6) @(posedge pclk);
	endtask : run

	task automatic cmd1(input logic [7:0] op);
		tx_q = '{op};
		run();
	endtask : cmd1

	task automatic wait_idle();
		for (int i = 0; i < 2000 && busy !== 1'b0; i++)
			@(posedge pclk);
		if (busy !== 1'b0)
			give_up("busy wait");
	endtask : wait_idle

	////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("dummy", dummy_clocks, 32'h0000_0002);
		chk("wrap", wrap_bytes, 32'h0000_0008);
		apb(1'b0, 12'h010, 32'h0000_0000);
		chk("slverr", err, 32'h0000_0001);
		tx_q = '{OP_READ_ID, 8'h00, 8'h00, 8'h00};
		run();
		chk("maker", rx_q[1], MAKER_ID);
		chk("type", rx_q[2], MEMORY_TYPE_ID);
		chk("capacity", rx_q[3], CAPACITY_ID);
		tx_q = '{OP_PARAM_TABLE, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00,
			8'h00};
		run();
		chk("table 2", rx_q[5], 32'h0000_0044);
		chk("table 3", rx_q[6], 32'h0000_0050);
		chk("table 4", rx_q[7], 32'h0000_00FF);
		// erase refused: no latch, then select raised off the boundary
		tx_q = '{OP_OTP_ERASE, 8'h00, 8'h10, 8'h00};
		run();
		chk("erase no latch", busy, 32'h0000_0000);
		cmd1(OP_WRITE_ENABLE);
		tx_q = '{OP_OTP_ERASE, 8'h00, 8'h10, 8'h00, 8'h00};
		run();
		chk("erase misaligned", busy, 32'h0000_0000);
		tx_q = '{OP_OTP_ERASE, 8'h00, 8'h10, 8'h00};
		run();
		chk("erase busy", busy, 32'h0000_0001);
		// status stays readable mid-erase: latch and busy both set
		tx_q = '{OP_READ_STATUS, 8'h00};
		run();
		chk("status busy", rx_q[1], 32'h0000_0003);
		wait_idle();
		chk("latch after erase", write_enable_latch, 32'h0000_0000);
		cmd1(OP_WRITE_ENABLE);
		tx_q = '{OP_OTP_PROGRAM, 8'h00, 8'h10, 8'hFE, 8'hA5, 8'h3C, 8'h7E};
		run();
		wait_idle();
		tx_q = '{OP_OTP_READ, 8'h00, 8'h10, 8'hFE, 8'h00, 8'h00, 8'h00,
			8'h00, 8'h00};
		run();
		chk("read fe", rx_q[5], 32'h0000_00A5);
		chk("read ff", rx_q[6], 32'h0000_003C);
		chk("read 00", rx_q[7], 32'h0000_007E);
		chk("read 01", rx_q[8], 32'h0000_00FF);
		// region one locked: erase and program both dropped
		otp_region_lock_bits <= 3'h1;
		cmd1(OP_WRITE_ENABLE);
		tx_q = '{OP_OTP_ERASE, 8'h00, 8'h10, 8'h00};
		run();
		chk("locked erase", busy, 32'h0000_0000);
		tx_q = '{OP_OTP_PROGRAM, 8'h00, 8'h10, 8'h01, 8'h00};
		run();
		wait_idle();
		chk("locked latch", write_enable_latch, 32'h0000_0001);
		otp_region_lock_bits <= 3'h0;
		tx_q = '{OP_OTP_ERASE, 8'h00, 8'h20, 8'h00};
		run();
		// opened while busy; the erase ends before the data bytes
		tx_q = '{OP_OTP_READ, 8'h00, 8'h10, 8'hFE, 8'h00, 8'h00};
		run();
		chk("read while busy", rx_q[5], 32'h0000_0000);
		wait_idle();
		tx_q = '{OP_OTP_READ, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00};
		run();
		chk("locked program", rx_q[6], 32'h0000_00FF);
		tx_q = '{OP_SET_READ_PARAMS, 8'h31};
		run();
		chk("serial dummy", dummy_clocks, 32'h0000_0002);
		chk("serial wrap", wrap_bytes, 32'h0000_0008);
		quad_instruction_mode <= 1'b1;
		for (int f = 0; f < 4; f++)
		begin
			tx_q = '{OP_SET_READ_PARAMS, 8'(f * 16 + 3 - f)};
			run();
			chk("quad dummy", dummy_clocks, 32'(2 + 2 * f));
			chk("quad wrap", wrap_bytes, 32'(8 << (3 - f)));
		end
		// wrap chosen in serial mode survives quad entry
		quad_instruction_mode <= 1'b0;
		serial_wrap_field <= 2'h2;
		serial_wrap_load <= 1'b1;
		@(posedge pclk);
		serial_wrap_load <= 1'b0;
		@(posedge pclk);
		quad_instruction_mode <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("wrap kept", wrap_bytes, 32'h0000_0020);
		cmd1(OP_WRITE_ENABLE);
		cmd1(OP_RESET_ENABLE);
		cmd1(OP_RESET);
		repeat (4) @(posedge pclk);
		chk("soft dummy", dummy_clocks, 32'h0000_0002);
		chk("soft wrap", wrap_bytes, 32'h0000_0008);
		summarize();
	end
endmodule : tb_top
